// *** hpc_pkg.sv ***
// Constants, types and register layout of the hot-plug control block.
// Assumes one 20 MHz clock; all users import the whole package.
// Summary of operation
// - The reset cycle ends only after the standby supply has stayed valid for 250 us.
// - When the reset cycle ends every control, status and mask register and every slot output holds its cleared value; status still shows the live input pins.
// - Losing and regaining the standby supply starts a fresh reset cycle.
// - Management bus accesses are served only after the reset cycle has ended.
// - All slot supply outputs stay off while the reset cycle runs.
// - Power is controlled either from the bus or from the enable pins, other registers stay open.
// - The pin port has a main enable and an aux enable per slot and a low fault output per slot.
// - The bus port uses SMBus data and clock plus a low alert output with SMBus timing.
// - The host can read measured output voltage and current of every supply.
// - The host can read fault state of every supply and both general input levels.
package hpc_pkg;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NSLOT    = 2;
  localparam int NGPI     = 2;
  localparam int NREG     = 16;
  localparam int NMEAS    = 12;
  localparam int AXI_AW   = 8;
  localparam int SYNC_W   = 3 + 4 * NSLOT;

  // ---------------------------------------------------------------
  // Register indices, byte address is index times four
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_STAT     = 4'h1;
  localparam logic [3:0] REG_INT_STAT = 4'h2;
  localparam logic [3:0] REG_INT_MASK = 4'h3;
  localparam logic [3:0] REG_MEAS0    = 4'h4;

  // Control field positions
  localparam int CTRL_BUS_MODE = 0;
  localparam int CTRL_MAIN_LSB = 1;
  localparam int CTRL_AUX_LSB  = 3;
  localparam int CTRL_PWR_W    = 4;
  // Event positions in status and mask
  localparam int EV_FAULT_LSB  = 0;
  localparam int EV_GPI_LSB    = 2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int POR_TIME_NS   = 250000;
  localparam int POR_CYCLES    = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bus constants
  localparam logic [6:0] SMB_ADDR_DEF = 7'h2a;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    SMB_IDLE, SMB_RX, SMB_ACK, SMB_TX, SMB_RACK
  } hpc_smb_e;

  // One register write request from either bus
  typedef struct packed {
    logic       en;
    logic [3:0] idx;
    logic [7:0] data;
  } hpc_wr_s;
endpackage : hpc_pkg

// *** hpc_ctrl.sv ***
// Hot-plug power control: reset sequencing, pin or bus power control,
// SMBus slave and AXI4-Lite slave onto one small register file.
// Assumes pins and SCL/SDA are asynchronous; meas_in comes from on-clock ADC logic.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module hpc_ctrl #(
  parameter int         POR_CYCLES = hpc_pkg::POR_CYCLES,
  parameter logic [6:0] SMB_ADDR   = hpc_pkg::SMB_ADDR_DEF
) (
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire logic                              stby_ok,
  input  wire logic [hpc_pkg::NSLOT-1:0]         main_enable_in,
  input  wire logic [hpc_pkg::NSLOT-1:0]         aux_enable_in,
  input  wire logic [hpc_pkg::NSLOT-1:0]         slot_fault_in,
  input  wire logic [hpc_pkg::NGPI-1:0]          general_input_pins,
  input  wire logic [hpc_pkg::NMEAS-1:0][7:0]    meas_in,
  output logic      [hpc_pkg::NSLOT-1:0]         main_out,
  output logic      [hpc_pkg::NSLOT-1:0]         aux_out,
  output logic      [hpc_pkg::NSLOT-1:0]         fault_n,
  input  wire logic                              scl_in,
  input  wire logic                              sda_in,
  output logic                                   sda_out,
  output logic                                   sda_oe,
  output logic                                   alert_n,
  output logic                                   irq,
  output logic                                   por_done,
  input  wire logic [hpc_pkg::AXI_AW-1:0]        s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [hpc_pkg::AXI_AW-1:0]        s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready
);
  import hpc_pkg::*;

  localparam int CW = $clog2(POR_CYCLES + 1);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] sy1;
  logic [SYNC_W-1:0] sy;
  logic              stby_s;
  logic              scl_s;
  logic              sda_s;
  logic [NSLOT-1:0]  main_en_s;
  logic [NSLOT-1:0]  aux_en_s;
  logic [NSLOT-1:0]  fault_s;
  logic [NGPI-1:0]   gpi_s;

  // Two flops per pin; only the second stage feeds logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy1 <= '0;
      sy  <= '0;
    end else begin
      sy1 <= {stby_ok, scl_in, sda_in, main_enable_in, aux_enable_in,
              slot_fault_in, general_input_pins};
      sy  <= sy1;
    end
  end

  assign {stby_s, scl_s, sda_s, main_en_s, aux_en_s, fault_s, gpi_s} = sy;

  // ---------------------------------------------------------------
  // Power-on reset qualification
  // ---------------------------------------------------------------
  logic [CW-1:0] por_cnt;
  logic          clr;

  // Any dip of the standby level restarts the whole count
  always_ff @(posedge aclk) begin
    if (!aresetn || !stby_s) begin
      por_cnt  <= '0;
      por_done <= 1'b0;
    end else if (!por_done) begin
      if (por_cnt == CW'(POR_CYCLES - 1)) begin
        por_done <= 1'b1;
      end else begin
        por_cnt <= por_cnt + 1'b1;
      end
    end
  end

  // Slot control, registers and the SMBus byte engine are held cleared until qualification ends
  assign clr = !aresetn || !por_done;

  // ---------------------------------------------------------------
  // Register write port, shared by both buses
  // ---------------------------------------------------------------
  hpc_wr_s    wr;
  logic       smb_wr;
  logic       axi_wr;
  logic [3:0] ptr;
  logic [7:0] sh;
  logic [7:0] aw_data;
  logic [3:0] aw_idx;

  assign wr.en   = smb_wr | axi_wr;
  assign wr.idx  = smb_wr ? ptr : aw_idx;
  assign wr.data = smb_wr ? sh : aw_data;

  // ---------------------------------------------------------------
  // Registers and slot control
  // ---------------------------------------------------------------
  logic [7:0]        ctrl;
  logic [7:0]        int_stat;
  logic [7:0]        int_mask;
  logic [7:0]        stat;
  logic [NSLOT-1:0]  trip;
  logic [NSLOT-1:0]  fault_q;
  logic [NGPI-1:0]   gpi_q;
  logic [NSLOT-1:0]  main_req;
  logic [NSLOT-1:0]  aux_req;
  logic [NSLOT-1:0]  fault_ev;
  logic [7:0]        events;
  logic [7:0]        w1c;
  logic              wr_ctrl;
  logic              bus_mode;

  assign bus_mode = ctrl[CTRL_BUS_MODE];
  assign wr_ctrl  = wr.en && wr.idx == REG_CTRL;
  assign w1c      = (wr.en && wr.idx == REG_INT_STAT) ? wr.data : 8'h00;
  assign events   = 8'({gpi_s ^ gpi_q, fault_ev});
  assign stat     = {aux_out, main_out, gpi_s, trip};

  // Per-slot source select, trip latch and outputs
  for (genvar i = 0; i < NSLOT; i++) begin : g_slot
    assign main_req[i] = bus_mode ? ctrl[CTRL_MAIN_LSB + i] : main_en_s[i];
    assign aux_req[i]  = bus_mode ? ctrl[CTRL_AUX_LSB + i] : aux_en_s[i];
    assign fault_ev[i] = fault_s[i] & ~fault_q[i] & ~trip[i] & (main_req[i] | aux_req[i]);

    // Trip holds until both enables drop, so a fault cannot retry by itself
    always_ff @(posedge aclk) begin
      if (clr) begin
        trip[i]     <= 1'b0;
        main_out[i] <= 1'b0;
        aux_out[i]  <= 1'b0;
        fault_n[i]  <= 1'b1;
      end else begin
        trip[i]     <= fault_ev[i] | (trip[i] & (main_req[i] | aux_req[i]));
        main_out[i] <= main_req[i] & ~trip[i] & ~fault_ev[i];
        aux_out[i]  <= aux_req[i] & ~trip[i] & ~fault_ev[i];
        fault_n[i]  <= ~(trip[i] | fault_ev[i]);
      end
    end
  end

  // Control, interrupt status and mask
  // Edge history tracks the pins during reset so no false event follows it
  always_ff @(posedge aclk) begin
    if (clr) begin
      ctrl     <= '0;
      int_stat <= '0;
      int_mask <= '0;
      fault_q  <= fault_s;
      gpi_q    <= gpi_s;
      irq      <= 1'b0;
      alert_n  <= 1'b1;
    end else begin
      fault_q <= fault_s;
      gpi_q   <= gpi_s;
      // Power bits only stick in bus mode; pin mode drops them
      if (wr_ctrl) begin
        ctrl <= 8'({wr.data[CTRL_AUX_LSB+1:CTRL_MAIN_LSB] & {CTRL_PWR_W{wr.data[CTRL_BUS_MODE]}},
                    wr.data[CTRL_BUS_MODE]});
      end
      if (wr.en && wr.idx == REG_INT_MASK) begin
        int_mask <= wr.data;
      end
      // New events win over a clear in the same cycle
      int_stat <= (int_stat & ~w1c) | events;
      irq      <= |(int_stat & int_mask);
      alert_n  <= ~|(int_stat & int_mask);
    end
  end

  // Read view: index 0 is ctrl, measurements from REG_MEAS0 up
  logic [NREG-1:0][7:0] rmap;
  assign rmap = {meas_in, int_mask, int_stat, stat, ctrl};

  // ---------------------------------------------------------------
  // SMBus slave
  // ---------------------------------------------------------------
  hpc_smb_e   st;
  logic [2:0] bcnt;
  logic [1:0] bno;
  logic       rd;
  logic       got;
  logic       scl_q;
  logic       sda_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       byte_end;
  logic       addr_hit;
  logic [3:0] nptr;
  logic [7:0] rx_byte;

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_c  = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c   = scl_s & scl_q & ~sda_q & sda_s;
  assign rx_byte  = {sh[6:0], sda_s};
  assign nptr     = ptr + 4'h1;
  assign byte_end = st == SMB_RX && scl_fall && got;
  assign addr_hit = sh[7:1] == SMB_ADDR;
  assign smb_wr   = byte_end && bno == 2'h2;

  // Line history, kept outside reset so edges are seen right away
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // Byte engine; held idle during reset so the address is never acked
  always_ff @(posedge aclk) begin
    if (clr) begin
      st   <= SMB_IDLE;
      sh   <= '0;
      bcnt <= '0;
      bno  <= '0;
      rd   <= 1'b0;
      got  <= 1'b0;
      ptr  <= '0;
    end else if (start_c) begin
      st   <= SMB_RX;
      bcnt <= '0;
      bno  <= '0;
      got  <= 1'b0;
    end else if (stop_c) begin
      st <= SMB_IDLE;
    end else begin
      unique case (st)
        SMB_IDLE: ;
        SMB_RX: begin
          if (scl_rise) begin
            sh   <= rx_byte;
            bcnt <= bcnt + 3'h1;
            got  <= bcnt == 3'h7;
          end else if (byte_end) begin
            got <= 1'b0;
            bno <= (bno == 2'h2) ? bno : bno + 2'h1;
            if (bno == 2'h0 && !addr_hit) begin
              st <= SMB_IDLE;
            end else begin
              st <= SMB_ACK;
            end
            if (bno == 2'h0) begin
              rd <= sh[0];
            end
            if (bno == 2'h1) begin
              ptr <= sh[3:0];
            end
            if (bno == 2'h2) begin
              ptr <= nptr;
            end
          end
        end
        SMB_ACK: begin
          if (scl_fall) begin
            st   <= rd ? SMB_TX : SMB_RX;
            sh   <= rmap[ptr];
            bcnt <= '0;
          end
        end
        SMB_TX: begin
          if (scl_fall) begin
            bcnt <= bcnt + 3'h1;
            if (bcnt == 3'h7) begin
              st <= SMB_RACK;
            end else begin
              sh <= {sh[6:0], 1'b0};
            end
          end
        end
        SMB_RACK: begin
          // Master nack ends the read; ack fetches the next register
          if (scl_rise && sda_s) begin
            st <= SMB_IDLE;
          end else if (scl_fall) begin
            st  <= SMB_TX;
            ptr <= nptr;
            sh  <= rmap[nptr];
          end
        end
      endcase
    end
  end

  // Open-drain data: pull low for ack and for zero bits
  always_ff @(posedge aclk) begin
    if (clr) begin
      sda_oe  <= 1'b0;
    end else begin
      sda_oe  <= st == SMB_ACK || (st == SMB_TX && !sh[7]);
    end
  end

  always_ff @(posedge aclk) begin
    sda_out <= 1'b0;
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave; it answers even during reset, writes then drop
  // ---------------------------------------------------------------
  logic       aw_got;
  logic       w_got;
  logic       aw_map;
  logic       w_lane;
  logic       wr_go;
  logic       ar_map;

  assign wr_go  = aw_got && w_got && !s_axi_bvalid && !smb_wr;
  assign axi_wr = wr_go && aw_map && w_lane && por_done;
  assign ar_map = s_axi_araddr[AXI_AW-1:6] == '0;

  // Address and data taken in either order, answered together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_map        <= 1'b0;
      w_lane        <= 1'b0;
      aw_idx        <= '0;
      aw_data       <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got        <= 1'b1;
        s_axi_awready <= 1'b0;
        aw_idx        <= s_axi_awaddr[5:2];
        aw_map        <= s_axi_awaddr[AXI_AW-1:6] == '0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got        <= 1'b1;
        s_axi_wready <= 1'b0;
        aw_data      <= s_axi_wdata[7:0];
        w_lane       <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= aw_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Reads answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= ar_map ? 32'(rmap[s_axi_araddr[5:2]]) : 32'h0;
      s_axi_rresp   <= ar_map ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : hpc_ctrl

// *** hpc_ctrl_chk.sv ***
// Concurrent checks on the hot-plug control block.
// Assumes it is bound onto hpc_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module hpc_ctrl_chk #(
  parameter int POR_CYCLES = hpc_pkg::POR_CYCLES
) (
  input wire logic                      aclk,
  input wire logic                      aresetn,
  input wire logic                      stby_ok,
  input wire logic [hpc_pkg::NSLOT-1:0] main_out,
  input wire logic [hpc_pkg::NSLOT-1:0] aux_out,
  input wire logic [hpc_pkg::NSLOT-1:0] fault_n,
  input wire logic                      sda_oe,
  input wire logic                      alert_n,
  input wire logic                      irq,
  input wire logic                      por_done,
  input wire logic                      s_axi_awvalid,
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_wvalid,
  input wire logic                      s_axi_wready,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic                      s_axi_rvalid
);
  import hpc_pkg::*;
  // ----------------------------------------
  // Helper: cycles of unbroken standby supply
  // ----------------------------------------
  logic [15:0] stby_cnt;
  logic [15:0] next_stby_cnt;
  // Saturates so a long run never wraps to a false short count
  assign next_stby_cnt = !stby_ok ? 16'h0 : (&stby_cnt ? stby_cnt : stby_cnt + 16'h1);
  always_ff @(posedge aclk) begin
    if (!aresetn) stby_cnt <= 16'h0;
    else stby_cnt <= next_stby_cnt;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_por_len;
    $rose(por_done) |-> stby_cnt >= POR_CYCLES;
  endproperty
  a_por_len: assert property (p_por_len) else $error("reset ended early");
  property p_por_clear;
    $rose(por_done) |-> !irq && alert_n && (&fault_n);
  endproperty
  a_por_clear: assert property (p_por_clear) else $error("state not clear");
  property p_stby_loss;
    $fell(stby_ok) |-> ##[1:5] !por_done;
  endproperty
  a_stby_loss: assert property (p_stby_loss) else $error("no new reset");
  property p_out_off;
    !por_done && !$past(por_done) |-> main_out == '0 && aux_out == '0;
  endproperty
  a_out_off: assert property (p_out_off) else $error("slot on in reset");
  property p_no_ack;
    !por_done |-> !sda_oe;
  endproperty
  a_no_ack: assert property (p_no_ack) else $error("bus driven in reset");
  property p_alert;
    alert_n == !irq;
  endproperty
  a_alert: assert property (p_alert) else $error("alert disagrees");
  property p_trip_off;
    !fault_n[0] && !$past(fault_n[0]) |-> !main_out[0] && !aux_out[0];
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("tripped slot on");
  property p_wr_resp;
    s_wr_take |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("late write reply");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("reply dropped");
  property p_rd_resp;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("late read reply");
endmodule : hpc_ctrl_chk

bind hpc_ctrl hpc_ctrl_chk #(.POR_CYCLES(POR_CYCLES)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .stby_ok(stby_ok), .main_out(main_out),
  .aux_out(aux_out), .fault_n(fault_n), .sda_oe(sda_oe), .alert_n(alert_n),
  .irq(irq), .por_done(por_done), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

// *** hpc_smb_host.sv ***
// Behavioural SMBus host driving the block's management port.
// Assumes a pulled-up SDA; SCL idles high between frames, 400 ns per bit.
`timescale 1ns/1ps
module hpc_smb_host (
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic sda_rel;
  // Wired-AND: pull-up wins unless either party pulls low
  assign sda = sda_rel & ~sda_oe;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // ----------------------------------------
  // Byte and frame tasks
  // ----------------------------------------
  // Data changes only while SCL is low, MSB first
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_rel = b[i];
      #100 scl = 1'b1;
      #200 scl = 1'b0;
      #100;
    end
    sda_rel = 1'b1;
    #100 scl = 1'b1;
    #100 ack = ~sda;
    #100 scl = 1'b0;
    #100;
  endtask : put_byte
  // One register write; acks = {address, index, data}
  task automatic write_reg(input logic [6:0] a, input logic [3:0] idx,
                           input logic [7:0] d, output logic [2:0] acks);
    sda_rel = 1'b0;
    #200 scl = 1'b0;
    #100;
    put_byte({a, 1'b0}, acks[2]);
    put_byte({4'h0, idx}, acks[1]);
    put_byte(d, acks[0]);
    sda_rel = 1'b0;
    #100 scl = 1'b1;
    #200 sda_rel = 1'b1;
    #400;
  endtask : write_reg
endmodule : hpc_smb_host

// *** tb.sv ***
// Self-checking bench for the hot-plug control block.
// Assumes the package, hpc_ctrl, its checker and the SMBus host model.
`timescale 1ns/1ps
module tb;
  import hpc_pkg::*;
  localparam int PORC = 200;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic stby_ok = 1'b0;
  logic [NSLOT-1:0] main_en = '0, aux_en = '0, flt = '0, main_out, aux_out, fault_n;
  logic [NGPI-1:0] gpi = '0;
  logic [NMEAS-1:0][7:0] meas = '0;
  logic scl, sda, sda_out, sda_oe, alert_n, irq, por_done;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [33:0] v;
  logic [2:0] acks;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;

  always #25 aclk = ~aclk;
  hpc_ctrl #(.POR_CYCLES(PORC)) dut (
    .aclk(aclk), .aresetn(aresetn), .stby_ok(stby_ok), .main_enable_in(main_en),
    .aux_enable_in(aux_en), .slot_fault_in(flt), .general_input_pins(gpi),
    .meas_in(meas), .main_out(main_out), .aux_out(aux_out), .fault_n(fault_n),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .alert_n(alert_n), .irq(irq), .por_done(por_done), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  hpc_smb_host host (.sda_oe(sda_oe), .scl(scl), .sda(sda));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check_val(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t ns: saw %h, wanted %h", $time, got, exp);
    end
  endtask : check_val
  function automatic logic [7:0] ra(input logic [3:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ra
  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        check_val(bresp, er);
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [33:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        r = {rresp, rdata};
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_rd
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  // Hang guard, well above the expected run length
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      complete_run();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    main_en <= 2'b11;
    aux_en <= 2'b11;
    gpi <= 2'b10;
    for (int k = 0; k < NMEAS; k++) meas[k] <= 8'(k * 17 + 1);
    stby_ok <= 1'b1;
    repeat (100) @(posedge aclk);
    stby_ok <= 1'b0; // Dip mid-count
    repeat (2) @(posedge aclk);
    stby_ok <= 1'b1;
    fork
      host.write_reg(SMB_ADDR_DEF, REG_INT_MASK, 8'h0c, acks);
      begin
        repeat (PORC - 5) @(posedge aclk);
        check_val(por_done, 1'b0);
        check_val({aux_out, main_out}, 4'h0);
      end
    join
    check_val(acks, 3'b000);
    check_val(por_done, 1'b1);
    axi_rd(ra(REG_STAT), v);
    check_val(v, 34'h0f8);
    host.write_reg(SMB_ADDR_DEF, REG_INT_MASK, 8'h0c, acks);
    check_val(acks, 3'b111);
    axi_rd(ra(REG_INT_MASK), v);
    check_val(v, 34'h00c);
    for (int k = 0; k < NMEAS; k++) begin
      axi_rd(ra(4'(REG_MEAS0 + k)), v);
      check_val(v, {26'h0, 8'(k * 17 + 1)});
    end
    axi_rd(8'h40, v);
    check_val(v, {RESP_SLVERR, 32'h0});
    axi_wr(8'h40, 8'h00, RESP_SLVERR);
    // Unmasked input change raises the interrupt line
    gpi <= 2'b11;
    repeat (6) @(posedge aclk);
    check_val({irq, alert_n}, 2'b10);
    axi_wr(ra(REG_INT_MASK), 8'h00, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check_val({irq, alert_n}, 2'b01);
    axi_wr(ra(REG_INT_STAT), 8'h04, RESP_OKAY);
    axi_rd(ra(REG_INT_STAT), v);
    check_val(v, 34'h0);
    // Fault on a powered slot trips only that slot
    flt <= 2'b01;
    repeat (6) @(posedge aclk);
    check_val({fault_n, main_out}, 4'b1010);
    axi_rd(ra(REG_STAT), v);
    check_val(v, 34'h0ad);
    axi_rd(ra(REG_INT_STAT), v);
    check_val(v, 34'h001);
    main_en <= 2'b10;
    aux_en <= 2'b10;
    flt <= 2'b00;
    repeat (6) @(posedge aclk);
    check_val(fault_n, 2'b11);
    // Bus mode: pins left idle, power from register
    main_en <= 2'b00;
    aux_en <= 2'b00;
    axi_wr(ra(REG_CTRL), 8'h1f, RESP_OKAY);
    repeat (6) @(posedge aclk);
    check_val({aux_out, main_out}, 4'hf);
    axi_rd(ra(REG_STAT), v);
    check_val(v, 34'h0fc);
    // Supply loss restarts the reset cycle
    stby_ok <= 1'b0;
    repeat (10) @(posedge aclk);
    check_val({por_done, aux_out, main_out}, 5'h0);
    stby_ok <= 1'b1;
    repeat (PORC + 10) @(posedge aclk);
    check_val(por_done, 1'b1);
    axi_rd(ra(REG_CTRL), v);
    check_val(v, 34'h0);
    check_val({aux_out, main_out}, 4'h0);
    complete_run();
  end
endmodule : tb
